/* File: hw/pmi_cfg.svh */
// Constants of the two-wire target interface: addresses, timing, counts.
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH

`define PMI_CLK_MHZ          200
`define PMI_OWN_ADDR         7'h58
`define PMI_RSVD_ADDR        7'h7F
`define PMI_RSVD_ADDR_BIG    7'h7E
`define PMI_BYTE_BITS        4'h8
`define PMI_STUCK_EDGES      8'h09
`define PMI_MAX_PRE_RESTART  3'h2
`define PMI_TLOW_SPEC_MS     35
`define PMI_TLOW_LATE_MS     5
`define PMI_WDOG_MS          100
`define PMI_TLOW_CYCLES \
	((`PMI_TLOW_SPEC_MS + `PMI_TLOW_LATE_MS) * `PMI_CLK_MHZ * 1000)
`define PMI_WDOG_CYCLES (`PMI_WDOG_MS * `PMI_CLK_MHZ * 1000)
`define PMI_FIFO_DEPTH       16
`define PMI_FIFO_WIDTH       8

`endif

/* File: hw/pmi_pkg.sv */
// Types shared by the two-wire target interface.
package pmi_pkg;

	typedef enum logic [6:0] {
		PMI_IDLE  = 7'h01,
		PMI_ADDR  = 7'h02,
		PMI_ACKA  = 7'h04,
		PMI_DATA  = 7'h08,
		PMI_ACKD  = 7'h10,
		PMI_STUCK = 7'h20,
		PMI_IGN   = 7'h40
	} pmi_state_t;

	typedef struct packed {
		logic [1:0]  scl_sy;
		logic [1:0]  sda_sy;
		logic [1:0]  big_sy;
		logic        scl_d;
		logic        sda_d;
		pmi_state_t  st;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        sda_low;
		logic        stretch;
		logic        push;
		logic [7:0]  push_data;
		logic [7:0]  stuck_cnt;
		logic [31:0] low_cnt;
		logic        tlow_pulse;
		logic [31:0] wd_cnt;
		logic        wd_pulse;
		logic [1:0]  pre_restart;
		logic        split_needed;
		logic        pcall_refused;
	} pmi_core_t;

endpackage : pmi_pkg

/* File: hw/pmi_stream_if.sv */
// Valid/ready byte stream between the target core and its FIFO.
`timescale 1ns/1ps
interface pmi_stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : pmi_stream_if

/* File: hw/pmi_fifo.sv */
// Receive FIFO with registered read data.
`timescale 1ns/1ps
module pmi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	pmi_stream_if.snk wr,
	pmi_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0]  wp;
		logic [AW-1:0]  rp;
		logic [AW:0]    cnt;
		logic           ov;
		logic [WIDTH-1:0] dout;
	} pmi_fifo_t;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("pmi_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	pmi_fifo_t        f_reg;
	pmi_fifo_t        f_next;
	logic             do_wr;
	logic             do_rd;

	assign wr.ready = (f_reg.cnt != DEPTH[AW:0]);
	assign rd.valid = f_reg.ov;
	assign rd.data  = f_reg.dout;
	assign do_wr    = wr.valid && wr.ready;
	// Prefetch into the output register whenever it is free or being taken.
	assign do_rd    = (f_reg.cnt != '0) && (!f_reg.ov || rd.ready);

	always_comb
	begin
		f_next = f_reg;
		if (do_wr)
		begin
			f_next.wp = f_reg.wp + 1'b1;
		end
		if (do_rd)
		begin
			f_next.rp   = f_reg.rp + 1'b1;
			f_next.dout = mem[f_reg.rp];
			f_next.ov   = 1'b1;
		end
		else if (rd.ready)
		begin
			f_next.ov = 1'b0;
		end
		f_next.cnt = f_reg.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			f_reg <= '0;
		end
		else
		begin
			f_reg <= f_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (do_wr)
		begin
			mem[f_reg.wp] <= wr.data;
		end
	end
endmodule : pmi_fifo

/* File: hw/pmi_target.sv */
// Two-wire bus target with stream output, timeouts and controller limits.
`timescale 1ns/1ps
`include "pmi_cfg.svh"
module pmi_target #(
	parameter logic [6:0]  OWN_ADDR    = `PMI_OWN_ADDR,
	parameter int unsigned TLOW_CYCLES = `PMI_TLOW_CYCLES,
	parameter int unsigned WDOG_CYCLES = `PMI_WDOG_CYCLES,
	parameter int          FIFO_DEPTH  = `PMI_FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       scl_i,
	output wire logic       scl_o,
	output wire logic       scl_oe_n,
	input  wire logic       sda_i,
	output wire logic       sda_o,
	output wire logic       sda_oe_n,
	input  wire logic       big_mem_variant,
	input  wire logic       fw_reset,
	output wire logic [7:0] rx_data,
	output wire logic       rx_valid,
	input  wire logic       rx_ready,
	output wire logic [7:0] bus_status_register,
	output wire logic       tlow_timeout,
	output wire logic       wdog_reset,
	output wire logic       scl_low_level,
	input  wire logic [2:0] ctl_pre_restart_req,
	input  wire logic       ctl_block_pcall_req,
	output wire logic [1:0] extended_pre_restart_bytes,
	output wire logic       ctl_split_needed,
	output wire logic       ctl_pcall_refused
);
	import pmi_pkg::*;

	generate
		if (TLOW_CYCLES < 2 || WDOG_CYCLES < 2 || FIFO_DEPTH < 2)
		begin : g_bad
			$error("pmi_target: counts and depth must be at least 2");
		end
	endgenerate

	pmi_core_t  c_reg;
	pmi_core_t  c_next;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       busy;
	logic       soft_rst;
	logic [6:0] rsvd;

	pmi_stream_if #(.WIDTH(`PMI_FIFO_WIDTH)) push_if ();
	pmi_stream_if #(.WIDTH(`PMI_FIFO_WIDTH)) pop_if ();

	pmi_fifo #(
		.WIDTH (`PMI_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.wr    (push_if.snk),
		.rd    (pop_if.src)
	);

	assign push_if.valid = c_reg.push;
	assign push_if.data  = c_reg.push_data;
	assign rx_valid      = pop_if.valid;
	assign rx_data       = pop_if.data;
	assign pop_if.ready  = rx_ready;

	assign scl_s    = c_reg.scl_sy[1];
	assign sda_s    = c_reg.sda_sy[1];
	assign scl_rise = scl_s && !c_reg.scl_d;
	assign scl_fall = !scl_s && c_reg.scl_d;
	assign start_c  = scl_s && c_reg.scl_d && !sda_s && c_reg.sda_d;
	assign stop_c   = scl_s && c_reg.scl_d && sda_s && !c_reg.sda_d;
	assign busy     = (c_reg.st != PMI_IDLE);
	assign soft_rst = fw_reset || c_reg.wd_pulse || c_reg.tlow_pulse;
	assign rsvd     = c_reg.big_sy[1] ? `PMI_RSVD_ADDR_BIG : `PMI_RSVD_ADDR;

	always_comb
	begin
		c_next = c_reg;
		c_next.scl_sy = {c_reg.scl_sy[0], scl_i};
		c_next.sda_sy = {c_reg.sda_sy[0], sda_i};
		c_next.big_sy = {c_reg.big_sy[0], big_mem_variant};
		c_next.scl_d  = scl_s;
		c_next.sda_d  = sda_s;
		c_next.push   = 1'b0;
		c_next.tlow_pulse = 1'b0;
		c_next.wd_pulse   = 1'b0;

		if (scl_rise)
		begin
			if (c_reg.bitcnt < `PMI_BYTE_BITS)
			begin
				c_next.shreg = {c_reg.shreg[6:0], sda_s};
			end
			c_next.bitcnt = (c_reg.bitcnt == `PMI_BYTE_BITS) ? 4'h0
				: c_reg.bitcnt + 4'h1;
		end

		unique case (c_reg.st)
			PMI_IDLE:
			begin
				c_next.sda_low = 1'b0;
			end
			PMI_ADDR:
			begin
				if (scl_fall && c_reg.bitcnt == `PMI_BYTE_BITS)
				begin
					if (c_reg.shreg[7:1] == rsvd)
					begin
						c_next.st        = PMI_STUCK;
						c_next.sda_low   = 1'b1;
						c_next.stuck_cnt = 8'h00;
					end
					else if (c_reg.shreg[7:1] == OWN_ADDR && !c_reg.shreg[0])
					begin
						c_next.st      = PMI_ACKA;
						c_next.sda_low = 1'b1;
					end
					else
					begin
						c_next.st = PMI_IGN;
					end
				end
			end
			PMI_DATA:
			begin
				if ((scl_fall || c_reg.stretch)
					&& c_reg.bitcnt == `PMI_BYTE_BITS)
				begin
					// Hold the clock low while the FIFO is full.
					if (push_if.ready)
					begin
						c_next.stretch   = 1'b0;
						c_next.push      = 1'b1;
						c_next.push_data = c_reg.shreg;
						c_next.sda_low   = 1'b1;
						c_next.st        = PMI_ACKD;
					end
					else
					begin
						c_next.stretch = 1'b1;
					end
				end
			end
			PMI_ACKA, PMI_ACKD:
			begin
				if (scl_fall && c_reg.bitcnt == 4'h0)
				begin
					c_next.sda_low = 1'b0;
					c_next.st      = PMI_DATA;
				end
			end
			PMI_STUCK:
			begin
				if (scl_fall)
				begin
					c_next.stuck_cnt = c_reg.stuck_cnt + 8'h01;
					if (c_reg.stuck_cnt == `PMI_STUCK_EDGES - 8'h01)
					begin
						c_next.sda_low = 1'b0;
						c_next.st      = PMI_IGN;
					end
				end
			end
			PMI_IGN:
			begin
				c_next.sda_low = 1'b0;
			end
		endcase

		if (start_c && c_reg.st != PMI_STUCK)
		begin
			c_next.st      = PMI_ADDR;
			c_next.sda_low = 1'b0;
			c_next.stretch = 1'b0;
		end
		if (stop_c)
		begin
			c_next.st      = PMI_IDLE;
			c_next.bitcnt  = 4'h0;
			c_next.sda_low = 1'b0;
			c_next.stretch = 1'b0;
		end
		if (soft_rst)
		begin
			c_next.st      = PMI_IDLE;
			c_next.sda_low = 1'b0;
			c_next.stretch = 1'b0;
		end

		if (scl_s || !busy)
		begin
			c_next.low_cnt = 32'h0;
		end
		else if (c_reg.low_cnt == TLOW_CYCLES - 1)
		begin
			c_next.low_cnt    = 32'h0;
			c_next.tlow_pulse = 1'b1;
		end
		else
		begin
			c_next.low_cnt = c_reg.low_cnt + 32'h1;
		end

		if (!busy || scl_rise || scl_fall)
		begin
			c_next.wd_cnt = 32'h0;
		end
		else if (c_reg.wd_cnt == WDOG_CYCLES - 1)
		begin
			c_next.wd_cnt   = 32'h0;
			c_next.wd_pulse = 1'b1;
		end
		else
		begin
			c_next.wd_cnt = c_reg.wd_cnt + 32'h1;
		end

		if (ctl_pre_restart_req > `PMI_MAX_PRE_RESTART)
		begin
			c_next.pre_restart  = 2'(`PMI_MAX_PRE_RESTART);
			c_next.split_needed = 1'b1;
		end
		else
		begin
			c_next.pre_restart  = ctl_pre_restart_req[1:0];
			c_next.split_needed = 1'b0;
		end
		c_next.pcall_refused = ctl_block_pcall_req;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			c_reg        <= '0;
			c_reg.scl_sy <= 2'h3;
			c_reg.sda_sy <= 2'h3;
			c_reg.scl_d  <= 1'b1;
			c_reg.sda_d  <= 1'b1;
			c_reg.st     <= PMI_IDLE;
		end
		else
		begin
			c_reg <= c_next;
		end
	end

	assign scl_o    = 1'b0;
	assign scl_oe_n = !c_reg.stretch;
	assign sda_o    = 1'b0;
	assign sda_oe_n = !c_reg.sda_low;
	assign scl_low_level = !scl_s;
	assign tlow_timeout  = c_reg.tlow_pulse;
	assign wdog_reset    = c_reg.wd_pulse;
	assign bus_status_register = {busy, c_reg.st == PMI_STUCK, c_reg.stretch,
		c_reg.sda_low, c_reg.bitcnt};
	assign extended_pre_restart_bytes = c_reg.pre_restart;
	assign ctl_split_needed  = c_reg.split_needed;
	assign ctl_pcall_refused = c_reg.pcall_refused;
endmodule : pmi_target

/* File: verif/pmi_target_monitor.sv */
// Port checker of the two-wire target.
`timescale 1ns/1ps
module pmi_target_monitor #(
	parameter int unsigned TLOW_CYCLES = 200
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       scl_oe_n,
	input wire logic       sda_oe_n,
	input wire logic       fw_reset,
	input wire logic       rx_valid,
	input wire logic [7:0] bus_status_register,
	input wire logic       tlow_timeout,
	input wire logic       wdog_reset,
	input wire logic       scl_low_level,
	input wire logic [2:0] ctl_pre_restart_req,
	input wire logic       ctl_block_pcall_req,
	input wire logic [1:0] extended_pre_restart_bytes,
	input wire logic       ctl_split_needed,
	input wire logic       ctl_pcall_refused
);
	logic [31:0] low_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Counts low clock cycles so the late timeout can be judged.
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			low_reg <= 32'h0;
		else
			low_reg <= scl_low_level ? low_reg + 32'h1 : 32'h0;
	a_reset_idle: assert property ($rose(rst_n) |-> sda_oe_n && scl_oe_n
		&& !rx_valid && bus_status_register == 8'h00)
		else $error("not idle after reset");
	a_grant_cap: assert property (1'b1 |=>
		{1'b0, extended_pre_restart_bytes} == ($past(ctl_pre_restart_req)
		> 3'h2 ? 3'h2 : $past(ctl_pre_restart_req)))
		else $error("grant count wrong");
	a_split_flag: assert property (1'b1 |=>
		ctl_split_needed == ($past(ctl_pre_restart_req) > 3'h2))
		else $error("split flag wrong");
	a_pcall_refuse: assert property (1'b1 |=>
		ctl_pcall_refused == $past(ctl_block_pcall_req))
		else $error("process call not refused");
	a_tlow_late: assert property (
		tlow_timeout |-> low_reg >= TLOW_CYCLES - 2)
		else $error("clock low timeout early");
	a_tlow_release: assert property (
		tlow_timeout |-> ##[1:2] (sda_oe_n && scl_oe_n))
		else $error("pins held after timeout");
	a_wdog_release: assert property (
		wdog_reset |-> ##[1:2] (sda_oe_n && scl_oe_n))
		else $error("pins held after watchdog");
	a_fw_keeps_count: assert property (
		fw_reset && scl_low_level ##1 scl_low_level |->
		bus_status_register[3:0] == $past(bus_status_register[3:0]))
		else $error("bit count changed by reset");
	a_stretch_full: assert property (!scl_oe_n |-> rx_valid)
		else $error("stretch without full buffer");
endmodule : pmi_target_monitor
bind pmi_target pmi_target_monitor #(.TLOW_CYCLES(TLOW_CYCLES)) u_mon (
	.clk                        (clk),
	.rst_n                      (rst_n),
	.scl_oe_n                   (scl_oe_n),
	.sda_oe_n                   (sda_oe_n),
	.fw_reset                   (fw_reset),
	.rx_valid                   (rx_valid),
	.bus_status_register        (bus_status_register),
	.tlow_timeout               (tlow_timeout),
	.wdog_reset                 (wdog_reset),
	.scl_low_level              (scl_low_level),
	.ctl_pre_restart_req        (ctl_pre_restart_req),
	.ctl_block_pcall_req        (ctl_block_pcall_req),
	.extended_pre_restart_bytes (extended_pre_restart_bytes),
	.ctl_split_needed           (ctl_split_needed),
	.ctl_pcall_refused          (ctl_pcall_refused)
);

/* File: verif/pmi_host_model.sv */
// Bus host model that drives both lines by open drain.
`timescale 1ns/1ps
module pmi_host_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_pull,
	output logic      sda_pull
);
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// Waits while the target stretches the clock.
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		#12;
		scl_pull = 1'b0;
		wait (scl);
		#12;
		r = sda;
		#12;
		scl_pull = 1'b1;
		#12;
	endtask : bit_io
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : send
	task automatic start();
		sda_pull = 1'b0;
		#12;
		scl_pull = 1'b0;
		wait (scl);
		#12;
		sda_pull = 1'b1;
		#12;
		scl_pull = 1'b1;
		#12;
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		#12;
		scl_pull = 1'b0;
		wait (scl);
		#12;
		sda_pull = 1'b0;
		#24;
	endtask : stop
	task automatic hold_start(input int ns);
		sda_pull = 1'b1;
		#(ns);
		sda_pull = 1'b0;
		#24;
	endtask : hold_start
endmodule : pmi_host_model

/* File: verif/tb.sv */
// Self-checking bench of the two-wire target.
`timescale 1ns/1ps
module tb;
	logic       clk, rst_n, big_mem_variant, fw_reset, rx_ready;
	logic       ctl_block_pcall_req;
	logic [2:0] ctl_pre_restart_req;
	wire        scl_i, sda_i, scl_o, sda_o, scl_oe_n, sda_oe_n, rx_valid;
	wire        tlow_timeout, wdog_reset, scl_low_level, ctl_split_needed;
	wire        ctl_pcall_refused, hs, hd;
	wire  [7:0] rx_data, bus_status_register;
	wire  [1:0] extended_pre_restart_bytes;
	int         fail_count, comparisons;
	assign scl_i = !hs && (scl_oe_n || scl_o);
	assign sda_i = !hd && (sda_oe_n || sda_o);
	pmi_target #(
		.TLOW_CYCLES (200),
		.WDOG_CYCLES (400)
	) uut (
		.clk                        (clk),
		.rst_n                      (rst_n),
		.scl_i                      (scl_i),
		.scl_o                      (scl_o),
		.scl_oe_n                   (scl_oe_n),
		.sda_i                      (sda_i),
		.sda_o                      (sda_o),
		.sda_oe_n                   (sda_oe_n),
		.big_mem_variant            (big_mem_variant),
		.fw_reset                   (fw_reset),
		.rx_data                    (rx_data),
		.rx_valid                   (rx_valid),
		.rx_ready                   (rx_ready),
		.bus_status_register        (bus_status_register),
		.tlow_timeout               (tlow_timeout),
		.wdog_reset                 (wdog_reset),
		.scl_low_level              (scl_low_level),
		.ctl_pre_restart_req        (ctl_pre_restart_req),
		.ctl_block_pcall_req        (ctl_block_pcall_req),
		.extended_pre_restart_bytes (extended_pre_restart_bytes),
		.ctl_split_needed           (ctl_split_needed),
		.ctl_pcall_refused          (ctl_pcall_refused)
	);
	pmi_host_model h (.scl(scl_i), .sda(sda_i),
		.scl_pull(hs), .sda_pull(hd));
	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] d, input logic exp);
		logic a;
		h.send(d, a);
		chk({7'h00, a}, {7'h00, exp});
	endtask : wr
	task automatic drain(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++)
		begin
			for (int k = 0; k < 200 && rx_valid !== 1'b1; k++)
				tick(1);
			chk(rx_data, base + i[7:0]);
			rx_ready = 1'b1;
			tick(1);
			rx_ready = 1'b0;
			tick(1);
		end
		chk({7'h00, rx_valid}, 8'h00);
	endtask : drain
	task automatic t_idle;
		chk({3'h0, scl_oe_n, sda_oe_n, rx_valid, tlow_timeout, wdog_reset},
			8'h18);
		chk({6'h00, scl_o, sda_o}, 8'h00);
		chk(bus_status_register, 8'h00);
		h.start();
		wr(8'hB2, 1'b0);
		h.stop();
		h.start();
		wr(8'hB1, 1'b0);
		h.stop();
	endtask : t_idle
	// The buffer fills with 17 acknowledged bytes, then the clock is stretched on the 18th.
	task automatic t_fill;
		h.start();
		wr(8'hB0, 1'b1);
		for (int i = 0; i < 17; i++)
			wr(8'h10 + i[7:0], 1'b1);
		fork
			wr(8'h21, 1'b1);
			begin
				for (int k = 0; k < 300 && scl_oe_n !== 1'b0; k++)
					tick(1);
				chk({7'h00, scl_oe_n}, 8'h00);
				chk({7'h00, bus_status_register[5]}, 8'h01);
				drain(18, 8'h10);
			end
		join
		h.stop();
	endtask : t_fill
	task automatic t_rsvd;
		logic a;
		for (int v = 0; v < 2; v++)
		begin
			big_mem_variant = v[0];
			tick(4);
			h.start();
			h.send({v[0] ? 7'h7E : 7'h7F, 1'b0}, a);
			chk({7'h00, a}, 8'h01);
			chk({7'h00, bus_status_register[6]}, 8'h01);
			h.send(8'hFF, a);
			h.send(8'hFF, a);
			chk({6'h00, a, sda_oe_n}, 8'h01);
			h.stop();
			h.start();
			wr(8'hB0, 1'b1);
			h.stop();
		end
	endtask : t_rsvd
	task automatic t_cut;
		logic r;
		h.start();
		repeat (3) h.bit_io(1'b1, r);
		tick(1);
		fw_reset = 1'b1;
		tick(1);
		fw_reset = 1'b0;
		tick(3);
		chk({4'h0, bus_status_register[3:0]}, 8'h03);
		h.start();
		wr(8'hB0, 1'b0);
		h.stop();
		h.start();
		wr(8'hB0, 1'b1);
		wr(8'h5A, 1'b1);
		h.stop();
		drain(1, 8'h5A);
	endtask : t_cut
	task automatic t_ctl;
		for (int i = 0; i < 8; i++)
		begin
			ctl_pre_restart_req = i[2:0];
			ctl_block_pcall_req = i[0];
			tick(2);
			chk({4'h0, extended_pre_restart_bytes, ctl_split_needed,
				ctl_pcall_refused}, {4'h0, i > 2 ? 2'h2 : i[1:0], i > 2,
				i[0]});
		end
	endtask : t_ctl
	task automatic t_tout;
		int k;
		h.start();
		for (k = 0; k < 400 && tlow_timeout !== 1'b1; k++)
			tick(1);
		chk({5'h00, k > 190, tlow_timeout, scl_low_level}, 8'h07);
		tick(3);
		chk({6'h00, sda_oe_n, scl_oe_n}, 8'h03);
		chk({4'h0, bus_status_register[7:4]}, 8'h00);
		h.stop();
		fork
			h.hold_start(3000);
			for (k = 0; k < 700 && wdog_reset !== 1'b1; k++)
				tick(1);
		join
		chk({7'h00, k > 390 && k < 700}, 8'h01);
	endtask : t_tout
	initial
	begin
		rst_n = 1'b0;
		big_mem_variant = 1'b0;
		fw_reset = 1'b0;
		rx_ready = 1'b0;
		ctl_block_pcall_req = 1'b0;
		ctl_pre_restart_req = 3'h0;
		tick(8);
		rst_n = 1'b1;
		tick(4);
		t_idle;
		t_fill;
		t_rsvd;
		t_cut;
		t_ctl;
		t_tout;
		give_verdict;
	end
	initial
	begin
		#100000;
		fail_count++;
		give_verdict;
	end
endmodule : tb
